// File: verilog/camr_pkg.sv
/*
 * Constants for the CAN acceptance mask register bank: byte addresses,
 * field positions, implemented-bit masks and widths.
 * Assumes an 8-bit register port with byte addresses.
 */
`default_nettype none
package camr_pkg;
	localparam int CAMR_ADDR_W = 8;
	localparam int CAMR_DATA_W = 8;
	localparam int CAMR_NUM_SETS = 2;
	localparam int CAMR_REGS_PER_SET = 4;
	// Byte addresses
	localparam logic [7:0] CAMR_M0_STD_HIGH = 8'h20;
	localparam logic [7:0] CAMR_M0_STD_LOW = 8'h21;
	localparam logic [7:0] CAMR_M0_EXT_HIGH = 8'h22;
	localparam logic [7:0] CAMR_M0_EXT_LOW = 8'h23;
	localparam logic [7:0] CAMR_M1_STD_HIGH = 8'h24;
	localparam logic [7:0] CAMR_M1_STD_LOW = 8'h25;
	localparam logic [7:0] CAMR_M1_EXT_HIGH = 8'h26;
	localparam logic [7:0] CAMR_M1_EXT_LOW = 8'h27;
	localparam logic [7:0] CAMR_BASE = CAMR_M0_STD_HIGH;
	// Register index within a set
	localparam logic [1:0] CAMR_IDX_STD_HIGH = 2'h0;
	localparam logic [1:0] CAMR_IDX_STD_LOW = 2'h1;
	localparam logic [1:0] CAMR_IDX_EXT_HIGH = 2'h2;
	localparam logic [1:0] CAMR_IDX_EXT_LOW = 2'h3;
	// Standard-low field layout
	localparam int CAMR_SL_STD_LSB = 5;
	localparam int CAMR_SL_EXT_LSB = 0;
	localparam logic [7:0] CAMR_SL_IMPL = 8'he3;
	localparam logic [7:0] CAMR_FULL_IMPL = 8'hff;
	localparam logic [7:0] CAMR_READ_ZERO = 8'h00;
	localparam int CAMR_STD_ID_W = 11;
	localparam int CAMR_EXT_ID_W = 18;
endpackage : camr_pkg
`default_nettype wire

// File: verilog/camr_addr_dec.sv
/*
 * Address decoder for the mask bank: splits a byte address into set
 * and register index and flags whether it hits the bank.
 * Assumes the address is stable beside the strobe in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module camr_addr_dec
	import camr_pkg::*;
(
	input wire logic [CAMR_ADDR_W-1:0] addr,
	output logic hit,
	output logic [0:0] set_sel,
	output logic [1:0] reg_idx
);
	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire logic [7:0] rel = addr - CAMR_BASE;
	assign hit = (addr >= CAMR_BASE) && (rel < 8'h08);
	assign set_sel = rel[2:2];
	assign reg_idx = rel[1:0];
endmodule : camr_addr_dec
`default_nettype wire

// File: verilog/camr_mask_set.sv
/*
 * One acceptance mask set: four byte registers with write masking,
 * read mux and the assembled standard and extended identifier masks.
 * Assumes writes arrive as a one-cycle enable with a register index.
 */
`timescale 1ns/1ps
`default_nettype none
module camr_mask_set
	import camr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [CAMR_DATA_W-1:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [CAMR_DATA_W-1:0] rd_data,
	output logic [CAMR_STD_ID_W-1:0] std_mask,
	output logic [CAMR_EXT_ID_W-1:0] ext_mask
);
	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [CAMR_DATA_W-1:0] regs_q [CAMR_REGS_PER_SET];

	// Implemented bits per register index
	function automatic logic [7:0] impl_bits(input logic [1:0] idx);
		impl_bits = (idx == CAMR_IDX_STD_LOW) ? CAMR_SL_IMPL : CAMR_FULL_IMPL;
	endfunction : impl_bits

	// Mask bits have no reset value; only writes change them
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			regs_q[wr_idx] <= wr_data & impl_bits(wr_idx);
		end
	end

	// Read mux, unimplemented bits forced to zero
	assign rd_data = regs_q[rd_idx] & impl_bits(rd_idx);

	// Assembled masks for the acceptance compare
	assign std_mask = {regs_q[CAMR_IDX_STD_HIGH],
		regs_q[CAMR_IDX_STD_LOW][CAMR_SL_STD_LSB +: 3]};
	assign ext_mask = {regs_q[CAMR_IDX_STD_LOW][CAMR_SL_EXT_LSB +: 2],
		regs_q[CAMR_IDX_EXT_HIGH],
		regs_q[CAMR_IDX_EXT_LOW]};
endmodule : camr_mask_set
`default_nettype wire

// File: verilog/camr_regs.sv
/*
 * Top of the CAN acceptance mask register bank: two mask sets behind a
 * plain register port, with registered read data and mask outputs.
 * Assumes a master on sys_clk issuing one-cycle, non-overlapping strobes.
 */
// Summary of operation
// - Standard-id-high mask registers at 20h and 24h hold mask for id bits 10..3.
// - Standard-id-low mask registers at 21h and 25h mix low std and top ext bits.
// - Standard-low bits 7..5 mask standard identifier bits 2..0.
// - Standard-low bits 1..0 mask extended identifier bits 17..16.
// - Ext-id-high registers at 22h and 26h mask extended bits 15..8.
// - Ext-id-low registers at 23h and 27h mask extended bits 7..0.
`timescale 1ns/1ps
`default_nettype none
module camr_regs
	import camr_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [CAMR_ADDR_W-1:0] reg_addr,
	input wire logic [CAMR_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [CAMR_DATA_W-1:0] reg_rdata,
	output logic [CAMR_STD_ID_W-1:0] mask0_std_id,
	output logic [CAMR_EXT_ID_W-1:0] mask0_ext_id,
	output logic [CAMR_STD_ID_W-1:0] mask1_std_id,
	output logic [CAMR_EXT_ID_W-1:0] mask1_ext_id
);
	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	logic hit;
	logic [0:0] set_sel;
	logic [1:0] reg_idx;

	camr_addr_dec u_dec (
		.addr(reg_addr),
		.hit(hit),
		.set_sel(set_sel),
		.reg_idx(reg_idx)
	);

	// ------------------------------------------------------------
	// Mask sets
	// ------------------------------------------------------------
	logic [CAMR_DATA_W-1:0] set_rd [CAMR_NUM_SETS];
	logic [CAMR_STD_ID_W-1:0] set_std [CAMR_NUM_SETS];
	logic [CAMR_EXT_ID_W-1:0] set_ext [CAMR_NUM_SETS];

	// One instance per set, write enable steered by the set bit
	for (genvar g = 0; g < CAMR_NUM_SETS; g++) begin : g_set
		wire logic set_wr = reg_wr && hit && (set_sel == 1'(g));
		camr_mask_set u_set (
			.sys_clk(sys_clk),
			.wr_en(set_wr),
			.wr_idx(reg_idx),
			.wr_data(reg_wdata),
			.rd_idx(reg_idx),
			.rd_data(set_rd[g]),
			.std_mask(set_std[g]),
			.ext_mask(set_ext[g])
		);
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	wire logic [CAMR_DATA_W-1:0] rd_sel = hit ? set_rd[set_sel] : CAMR_READ_ZERO;
	logic [CAMR_DATA_W-1:0] rdata_q;

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= CAMR_READ_ZERO;
		end else begin
			rdata_q <= reg_rd ? rd_sel : CAMR_READ_ZERO;
		end
	end
	assign reg_rdata = rdata_q;

	// ------------------------------------------------------------
	// Mask outputs, registered; content undefined until written
	// ------------------------------------------------------------
	logic [CAMR_STD_ID_W-1:0] m0_std_q;
	logic [CAMR_EXT_ID_W-1:0] m0_ext_q;
	logic [CAMR_STD_ID_W-1:0] m1_std_q;
	logic [CAMR_EXT_ID_W-1:0] m1_ext_q;

	always_ff @(posedge sys_clk) begin
		m0_std_q <= set_std[0];
		m0_ext_q <= set_ext[0];
		m1_std_q <= set_std[1];
		m1_ext_q <= set_ext[1];
	end
	assign mask0_std_id = m0_std_q;
	assign mask0_ext_id = m0_ext_q;
	assign mask1_std_id = m1_std_q;
	assign mask1_ext_id = m1_ext_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);

	sequence s_write(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence

	// A read strobe beside one address
	sequence s_read(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	// Write followed at once by a read of the same address
	sequence s_wr_rd(logic [7:0] a);
		s_write(a) ##1 s_read(a);
	endsequence

	a_std_high_rt: assert property (s_write(CAMR_M0_STD_HIGH) ##2 1 |->
		mask0_std_id[10:3] == $past(reg_wdata, 2))
		else $error("std high mask not taken");
	a_std_low_bits: assert property (s_write(CAMR_M1_STD_LOW) ##2 1 |->
		mask1_std_id[2:0] == $past(reg_wdata[7:5], 2))
		else $error("std low mask bits wrong");
	a_ext_top_bits: assert property (s_write(CAMR_M0_STD_LOW) ##2 1 |->
		mask0_ext_id[17:16] == $past(reg_wdata[1:0], 2))
		else $error("ext top mask bits wrong");
	a_ext_high_rt: assert property (s_write(CAMR_M1_EXT_HIGH) ##2 1 |->
		mask1_ext_id[15:8] == $past(reg_wdata, 2))
		else $error("ext high mask not taken");
	a_ext_low_rt: assert property (s_write(CAMR_M0_EXT_LOW) ##2 1 |->
		mask0_ext_id[7:0] == $past(reg_wdata, 2))
		else $error("ext low mask not taken");
	a_unimpl_zero: assert property ($past(reg_rd) &&
		($past(reg_addr) == CAMR_M0_STD_LOW || $past(reg_addr) == CAMR_M1_STD_LOW)
		|-> reg_rdata[4:2] == 3'h0)
		else $error("unimplemented bits read nonzero");
	a_set_isolate: assert property (s_write(CAMR_M1_STD_HIGH) |=>
		$stable(set_std[0]) && $stable(set_ext[0]))
		else $error("write to set 1 changed set 0");
	a_read_back: assert property (s_write(CAMR_M1_EXT_LOW) ##1
		(reg_rd && reg_addr == CAMR_M1_EXT_LOW) |=> reg_rdata == $past(reg_wdata, 2))
		else $error("read back mismatch");
	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside read");

	// ------------------------------------------------------------
	// Mapping of the remaining fields onto the mask outputs
	// ------------------------------------------------------------
	// A write shows on the mask output two edges later: one edge
	// stores the byte, the next one registers the assembled mask.

	// Set 1 standard-high byte
	a_std_high_m1: assert property (s_write(CAMR_M1_STD_HIGH) ##2 1 |->
		mask1_std_id[10:3] == $past(reg_wdata, 2))
		else $error("set 1 std high mask not taken");

	// Set 0 standard-low top bits
	a_std_low_m0: assert property (s_write(CAMR_M0_STD_LOW) ##2 1 |->
		mask0_std_id[2:0] == $past(reg_wdata[7:5], 2))
		else $error("set 0 std low mask bits wrong");

	// Set 1 extended top bits from the standard-low byte
	a_ext_top_m1: assert property (s_write(CAMR_M1_STD_LOW) ##2 1 |->
		mask1_ext_id[17:16] == $past(reg_wdata[1:0], 2))
		else $error("set 1 ext top mask bits wrong");

	// Set 0 extended-high byte
	a_ext_high_m0: assert property (s_write(CAMR_M0_EXT_HIGH) ##2 1 |->
		mask0_ext_id[15:8] == $past(reg_wdata, 2))
		else $error("set 0 ext high mask not taken");

	// Set 1 extended-low byte
	a_ext_low_m1: assert property (s_write(CAMR_M1_EXT_LOW) ##2 1 |->
		mask1_ext_id[7:0] == $past(reg_wdata, 2))
		else $error("set 1 ext low mask not taken");

	// ------------------------------------------------------------
	// Read back of every register but set 1 extended-low
	// ------------------------------------------------------------
	// A read right after a write to the same address must return
	// the new byte, with the unimplemented bits cleared.

	// Set 0 standard-high
	a_rb_m0_sh: assert property (s_wr_rd(CAMR_M0_STD_HIGH) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("set 0 std high read back mismatch");

	// Set 0 standard-low, bits 4..2 forced low
	a_rb_m0_sl: assert property (s_wr_rd(CAMR_M0_STD_LOW) |=>
		reg_rdata == ($past(reg_wdata, 2) & CAMR_SL_IMPL))
		else $error("set 0 std low read back mismatch");

	// Set 0 extended-high
	a_rb_m0_eh: assert property (s_wr_rd(CAMR_M0_EXT_HIGH) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("set 0 ext high read back mismatch");

	// Set 0 extended-low
	a_rb_m0_el: assert property (s_wr_rd(CAMR_M0_EXT_LOW) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("set 0 ext low read back mismatch");

	// Set 1 standard-high
	a_rb_m1_sh: assert property (s_wr_rd(CAMR_M1_STD_HIGH) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("set 1 std high read back mismatch");

	// Set 1 standard-low, bits 4..2 forced low
	a_rb_m1_sl: assert property (s_wr_rd(CAMR_M1_STD_LOW) |=>
		reg_rdata == ($past(reg_wdata, 2) & CAMR_SL_IMPL))
		else $error("set 1 std low read back mismatch");

	// Set 1 extended-high
	a_rb_m1_eh: assert property (s_wr_rd(CAMR_M1_EXT_HIGH) |=>
		reg_rdata == $past(reg_wdata, 2))
		else $error("set 1 ext high read back mismatch");

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// The decoder is checked against the plain address range, so a
	// slip in the subtraction or the compare shows up here.

	// Hit covers exactly the eight mask bytes
	a_hit_range: assert property ((reg_wr || reg_rd) |->
		hit == (reg_addr >= CAMR_M0_STD_HIGH && reg_addr <= CAMR_M1_EXT_LOW))
		else $error("address hit decode wrong");

	// Set bit follows the upper half of the range
	a_set_decode: assert property ((reg_wr || reg_rd) && hit |->
		set_sel == 1'(reg_addr >= CAMR_M1_STD_HIGH))
		else $error("set select decode wrong");

	// Register index is the byte within the set
	a_idx_decode: assert property ((reg_wr || reg_rd) && hit |->
		reg_idx == reg_addr[1:0])
		else $error("register index decode wrong");

	// Unmapped addresses read as zero
	a_unmapped_rd: assert property (reg_rd && !hit |=>
		reg_rdata == CAMR_READ_ZERO)
		else $error("unmapped read not zero");

	// ------------------------------------------------------------
	// Set isolation once a set is fully known
	// ------------------------------------------------------------
	// Mask bits have no reset, so a stability check on a set that
	// was never written would compare unknowns. Track which bytes
	// have been written since reset and check only known sets.
	logic [7:0] seen_q;
	wire logic set0_wr = reg_wr && hit && (set_sel == 1'b0);
	wire logic set1_wr = reg_wr && hit && (set_sel == 1'b1);
	wire logic set0_known = &seen_q[3:0];
	wire logic set1_known = &seen_q[7:4];

	// One flag per byte, set by the first write after reset
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			seen_q <= 8'h00;
		end else if (reg_wr && hit) begin
			seen_q[{set_sel, reg_idx}] <= 1'b1;
		end
	end

	// Set 0 outputs move only after a write to set 0
	a_set0_hold: assert property (set0_known && !$past(set0_wr) |=>
		$stable(mask0_std_id) && $stable(mask0_ext_id))
		else $error("set 0 mask moved without a write");

	// Set 1 outputs move only after a write to set 1
	a_set1_hold: assert property (set1_known && !$past(set1_wr) |=>
		$stable(mask1_std_id) && $stable(mask1_ext_id))
		else $error("set 1 mask moved without a write");

	// An unmapped write leaves the extended masks of both sets alone
	a_unmapped_wr: assert property (reg_wr && !hit && set0_known && set1_known
		&& !$past(set0_wr) && !$past(set1_wr) |=>
		$stable(mask0_ext_id) && $stable(mask1_ext_id))
		else $error("unmapped write changed a mask");
endmodule : camr_regs
`default_nettype wire

// File: testbench/test_can_acceptance_mask_regs.sv
/*
 * Self-checking bench for the acceptance mask register bank.
 * Assumes camr_pkg and camr_regs are compiled first; sys_clk 100 MHz.
 */
`timescale 1ns/1ps
`default_nettype none
module test_can_acceptance_mask_regs
	import camr_pkg::*;
;
	typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} camr_row_s;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata;
	logic [10:0] m0_std, m1_std;
	logic [17:0] m0_ext, m1_ext;
	int fails = 0;
	int checks_done = 0;
	camr_row_s rows [10];

	camr_regs dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.mask0_std_id(m0_std), .mask0_ext_id(m0_ext),
		.mask1_std_id(m1_std), .mask1_ext_id(m1_ext));

	// Free-running 10 ns clock
	always #5 sys_clk = ~sys_clk;

	// -------------------------------------------------------------
	// Bus cycles and comparison
	// -------------------------------------------------------------
	// One bus cycle: drive all strobes once, then wait for the edge
	task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
	endtask : op

	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic finish_test;
		$display("checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// -------------------------------------------------------------
	// Main sequence
	// -------------------------------------------------------------
	// Rows: address, write data, expected read back
	initial begin
		rows[0] = {8'h20, 8'ha5, 8'ha5};
		rows[1] = {8'h21, 8'hff, 8'he3};
		rows[2] = {8'h22, 8'h3c, 8'h3c};
		rows[3] = {8'h23, 8'h96, 8'h96};
		rows[4] = {8'h24, 8'h5a, 8'h5a};
		rows[5] = {8'h25, 8'h1c, 8'h00};
		rows[6] = {8'h26, 8'hc3, 8'hc3};
		rows[7] = {8'h27, 8'h69, 8'h69};
		rows[8] = {8'h28, 8'h77, 8'h00};
		rows[9] = {8'h1f, 8'h11, 8'h00};
		repeat (12) @(posedge sys_clk);
		chk(18'(reg_rdata), 18'h0);
		rstn <= 1'b1;
		@(posedge sys_clk);
		// Write then read back at once, then the read data must drop
		foreach (rows[i]) begin
			op(1'b1, 1'b0, rows[i].a, rows[i].d);
			op(1'b0, 1'b1, rows[i].a, 8'h00);
			#1 chk(18'(reg_rdata), 18'(rows[i].e));
			op(1'b0, 1'b0, 8'h00, 8'h00);
			#1 chk(18'(reg_rdata), 18'h0);
		end
		// Assembled masks after all writes, unmapped writes left them alone
		chk(18'(m0_std), 18'({rows[0].d, rows[1].d[7:5]}));
		chk(m0_ext, {rows[1].d[1:0], rows[2].d, rows[3].d});
		chk(18'(m1_std), 18'({rows[4].d, rows[5].d[7:5]}));
		chk(m1_ext, {rows[5].d[1:0], rows[6].d, rows[7].d});
		// Overwrite: mask output moves on the second edge after the write
		op(1'b1, 1'b0, 8'h27, 8'h0f);
		#1 chk(m1_ext, {2'h0, 8'hc3, 8'h69});
		op(1'b0, 1'b0, 8'h00, 8'h00);
		#1 chk(m1_ext, {2'h0, 8'hc3, 8'h0f});
		// Low std register: reserved bits stay zero, set 0 untouched
		op(1'b1, 1'b0, 8'h25, 8'hbe);
		op(1'b0, 1'b1, 8'h25, 8'h00);
		#1 chk(18'(reg_rdata), 18'ha2);
		op(1'b0, 1'b1, 8'h21, 8'h00);
		#1 chk(18'(reg_rdata), 18'he3);
		op(1'b0, 1'b0, 8'h00, 8'h00);
		#1 chk(18'(m1_std), 18'({8'h5a, 3'h5}));
		chk(m1_ext, {2'h2, 8'hc3, 8'h0f});
		// Reset in mid-run: read data clears, mask bits survive
		rstn <= 1'b0;
		op(1'b0, 1'b0, 8'h00, 8'h00);
		#1 chk(18'(reg_rdata), 18'h0);
		chk(m1_ext, {2'h2, 8'hc3, 8'h0f});
		rstn <= 1'b1;
		op(1'b0, 1'b1, 8'h27, 8'h00);
		#1 chk(18'(reg_rdata), 18'h0f);
		op(1'b0, 1'b0, 8'h00, 8'h00);
		#1 chk(18'(reg_rdata), 18'h0);
		finish_test();
	end

	// Watchdog: the sequence needs well under a thousand cycles
	initial begin
		#100000;
		fails++;
		finish_test();
	end
endmodule : test_can_acceptance_mask_regs
`default_nettype wire
